//--- shared/sld_pkg.sv
package sld_pkg;
   // widths
   localparam int SLD_BITS = 20;
   localparam int CNT_W    = 5;
   localparam int TMR_W    = 4;

   // clock rates
   localparam int CLK_PERIOD_NS = 25;
   localparam int CLK_KHZ       = 40000;
   localparam int SCLK_MAX_KHZ  = 3300;

   // link timing figures
   localparam int T_CLK_HIGH_NS   = 150;
   localparam int T_DATA_NS       = 150;
   localparam int T_CLK_TO_STB_NS = 300;
   localparam int T_STB_NS        = 100;

   // derived cycle counts, least times round up
   localparam int CYC_CLK_HIGH = (T_CLK_HIGH_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
   localparam int CYC_DATA     = (T_DATA_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
   localparam int CYC_PERIOD   = (CLK_KHZ + SCLK_MAX_KHZ - 1) / SCLK_MAX_KHZ;
   localparam int CYC_HIGH     = (CYC_CLK_HIGH > (CYC_PERIOD + 1) / 2) ?
                                 CYC_CLK_HIGH : (CYC_PERIOD + 1) / 2;
   localparam int CYC_LOW      = CYC_PERIOD - CYC_HIGH;
   localparam int CYC_STB_WAIT = (T_CLK_TO_STB_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
   localparam int CYC_STB      = (T_STB_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

   // reset values
   localparam logic [SLD_BITS-1:0] LATCH_RST = 20'h00000;
   localparam logic                BLANK_RST = 1'b1;

   typedef logic [SLD_BITS-1:0] sld_word_t;

   typedef enum logic [2:0] {
      H_IDLE,
      H_LOW,
      H_HIGH,
      H_WAIT,
      H_STB,
      H_DONE
   } sld_host_state_e;
endpackage

//--- shared/sld_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sld_link_if;
   logic sclk;
   logic sdata;
   logic strobe;
   logic blank;
   logic sout;

   modport dev (
      input  sclk,
      input  sdata,
      input  strobe,
      input  blank,
      output sout
   );

   modport host (
      output sclk,
      output sdata,
      output strobe,
      output blank,
      input  sout
   );
endinterface
`default_nettype wire

//--- rtl/sld_dev.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - shift clock rise captures serial input
// - later rises move bits toward serial output
// - latches load while transfer high, else hold
// - latches follow register while transfer high
// - blank high: sources off, pull-downs on
// - blank never alters latch contents
// - blank low: output follows own latch
// - host blanks while shifting with latches open
// - host keeps shift clock pulse 150 ns
// - host holds serial data 150 ns
// - host waits 300 ns before transfer
// - host keeps transfer pulse 100 ns
// - host shift clock at most 3.3 MHz
// - twenty-bit shift register and latches
// - serial output allows cascading devices
module sld_dev
   import sld_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic                ce,
   sld_link_if.dev                  link,
   input  wire logic                clr_err,
   output logic      [SLD_BITS-1:0] src_on,
   output logic      [SLD_BITS-1:0] pd_on,
   output logic      [SLD_BITS-1:0] latch_word,
   output logic      [SLD_BITS-1:0] shadow_word,
   output logic      [CNT_W-1:0]    frame_bits,
   output logic                     bits_passed,
   output logic                     blank_seen,
   output logic                     shift_seen,
   output logic                     err_early,
   output logic                     err_unblanked
);

   // link side, on the shift clock
   sld_word_t sreg_q;

   // clock domain side
   logic      sclk_s1_q;
   logic      sclk_s2_q;
   logic      sclk_s3_q;
   logic      stb_s1_q;
   logic      stb_s2_q;
   logic      stb_s3_q;
   logic      blk_s1_q;
   logic      blk_s2_q;
   logic      sclk_rise;
   logic      stb_rise;
   sld_word_t shadow_q;
   sld_word_t latch_q;
   sld_word_t src_q;
   sld_word_t pd_q;
   logic [CNT_W-1:0] bits_q;
   logic      passed_q;
   logic      shift_q;
   logic [TMR_W-1:0] gap_q;
   logic      early_q;
   logic      unblank_q;

   // shift register, no reset as the link has none
   always_ff @(posedge link.sclk) begin
      sreg_q <= {sreg_q[SLD_BITS-2:0], link.sdata};
   end

   // cascade output from last stage
   assign link.sout = sreg_q[SLD_BITS-1];

   // shift clock level into clk domain
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_s3_q <= 1'b0;
      end else if (ce) begin
         sclk_s1_q <= link.sclk;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
      end
   end

   // transfer input synchroniser
   always_ff @(posedge clk) begin
      if (!rstn) begin
         stb_s1_q <= 1'b0;
         stb_s2_q <= 1'b0;
         stb_s3_q <= 1'b0;
      end else if (ce) begin
         stb_s1_q <= link.strobe;
         stb_s2_q <= stb_s1_q;
         stb_s3_q <= stb_s2_q;
      end
   end

   // blank input synchroniser
   always_ff @(posedge clk) begin
      if (!rstn) begin
         blk_s1_q <= BLANK_RST;
         blk_s2_q <= BLANK_RST;
      end else if (ce) begin
         blk_s1_q <= link.blank;
         blk_s2_q <= blk_s1_q;
      end
   end

   assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
   assign stb_rise  = stb_s2_q & ~stb_s3_q;

   // shift register copy, taken while it is stable after an edge
   always_ff @(posedge clk) begin
      if (!rstn) begin
         shadow_q <= LATCH_RST;
      end else if (ce && sclk_rise) begin
         shadow_q <= sreg_q;
      end
   end

   // output latches, open while transfer is high
   always_ff @(posedge clk) begin
      if (!rstn) begin
         latch_q <= LATCH_RST;
      end else if (ce && stb_s2_q) begin
         latch_q <= shadow_q;
      end
   end

   // per-line drive stage
   genvar gi;
   generate
      for (gi = 0; gi < SLD_BITS; gi++) begin : g_line
         always_ff @(posedge clk) begin
            if (!rstn) begin
               src_q[gi] <= 1'b0;
               pd_q[gi]  <= 1'b1;
            end else if (ce) begin
               if (blk_s2_q) begin
                  src_q[gi] <= 1'b0;
                  pd_q[gi]  <= 1'b1;
               end else begin
                  src_q[gi] <= latch_q[gi];
                  pd_q[gi]  <= ~latch_q[gi];
               end
            end
         end
      end
   endgenerate

   // bits received since last transfer
   always_ff @(posedge clk) begin
      if (!rstn) begin
         bits_q   <= '0;
         passed_q <= 1'b0;
      end else if (ce) begin
         if (sclk_rise) begin
            if (bits_q == CNT_W'(SLD_BITS)) begin
               passed_q <= 1'b1;
            end else begin
               bits_q <= bits_q + CNT_W'(1);
            end
         end else if (stb_rise) begin
            bits_q   <= '0;
            passed_q <= 1'b0;
         end
      end
   end

   // one-cycle shift event
   always_ff @(posedge clk) begin
      if (!rstn) begin
         shift_q <= 1'b0;
      end else if (ce) begin
         shift_q <= sclk_rise;
      end
   end

   // cycles since last shift, saturating
   always_ff @(posedge clk) begin
      if (!rstn) begin
         gap_q <= TMR_W'(CYC_STB_WAIT);
      end else if (ce) begin
         if (sclk_rise) begin
            gap_q <= '0;
         end else if (gap_q != TMR_W'(CYC_STB_WAIT)) begin
            gap_q <= gap_q + TMR_W'(1);
         end
      end
   end

   // transfer raised too soon after a shift, sticky
   always_ff @(posedge clk) begin
      if (!rstn) begin
         early_q <= 1'b0;
      end else if (ce) begin
         if (stb_rise && gap_q != TMR_W'(CYC_STB_WAIT)) begin
            early_q <= 1'b1;
         end else if (clr_err) begin
            early_q <= 1'b0;
         end
      end
   end

   // shifting with latches open and outputs unblanked, sticky
   always_ff @(posedge clk) begin
      if (!rstn) begin
         unblank_q <= 1'b0;
      end else if (ce) begin
         if (sclk_rise && stb_s2_q && !blk_s2_q) begin
            unblank_q <= 1'b1;
         end else if (clr_err) begin
            unblank_q <= 1'b0;
         end
      end
   end

   assign src_on        = src_q;
   assign pd_on         = pd_q;
   assign latch_word    = latch_q;
   assign shadow_word   = shadow_q;
   assign frame_bits    = bits_q;
   assign bits_passed   = passed_q;
   assign blank_seen    = blk_s2_q;
   assign shift_seen    = shift_q;
   assign err_early     = early_q;
   assign err_unblanked = unblank_q;

endmodule
`default_nettype wire

//--- rtl/sld_host.sv
`timescale 1ns/10ps
`default_nettype none
module sld_host
   import sld_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic                ce,
   sld_link_if.host                 link,
   input  wire logic [SLD_BITS-1:0] word_in,
   input  wire logic                word_valid,
   output logic                     word_ready,
   input  wire logic                follow_mode,
   input  wire logic                blank_req,
   output logic                     busy,
   output logic                     done,
   output logic      [SLD_BITS-1:0] readback
);

   sld_host_state_e state_q;
   sld_word_t       data_q;
   sld_word_t       rb_q;
   logic [TMR_W-1:0] tmr_q;
   logic [CNT_W-1:0] idx_q;
   logic            follow_q;
   logic            sclk_q;
   logic            sdata_q;
   logic            strobe_q;
   logic            blank_q;
   logic            done_q;
   logic            sout_s1_q;
   logic            sout_s2_q;

   // transfer sequencer, shift clock by division of clk
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q  <= H_IDLE;
         data_q   <= '0;
         tmr_q    <= '0;
         idx_q    <= '0;
         follow_q <= 1'b0;
         sclk_q   <= 1'b0;
         sdata_q  <= 1'b0;
         strobe_q <= 1'b0;
         done_q   <= 1'b0;
      end else if (ce) begin
         done_q <= 1'b0;
         case (state_q)
            H_IDLE: begin
               strobe_q <= follow_mode;
               if (word_valid) begin
                  data_q   <= {word_in[SLD_BITS-2:0], 1'b0};
                  sdata_q  <= word_in[SLD_BITS-1];
                  follow_q <= follow_mode;
                  idx_q    <= '0;
                  tmr_q    <= TMR_W'(CYC_LOW - 1);
                  state_q  <= H_LOW;
               end
            end
            H_LOW: begin
               if (tmr_q == '0) begin
                  sclk_q  <= 1'b1;
                  tmr_q   <= TMR_W'(CYC_HIGH - 1);
                  state_q <= H_HIGH;
               end else begin
                  tmr_q <= tmr_q - TMR_W'(1);
               end
            end
            H_HIGH: begin
               if (tmr_q == '0) begin
                  sclk_q <= 1'b0;
                  if (idx_q == CNT_W'(SLD_BITS - 1)) begin
                     tmr_q   <= TMR_W'(CYC_STB_WAIT - 1);
                     state_q <= H_WAIT;
                  end else begin
                     // data held one full period of CYC_PERIOD
                     sdata_q <= data_q[SLD_BITS-1];
                     data_q  <= {data_q[SLD_BITS-2:0], 1'b0};
                     idx_q   <= idx_q + CNT_W'(1);
                     tmr_q   <= TMR_W'(CYC_LOW - 1);
                     state_q <= H_LOW;
                  end
               end else begin
                  tmr_q <= tmr_q - TMR_W'(1);
               end
            end
            H_WAIT: begin
               if (tmr_q != '0) begin
                  tmr_q <= tmr_q - TMR_W'(1);
               end else if (follow_q) begin
                  state_q <= H_DONE;
               end else begin
                  strobe_q <= 1'b1;
                  tmr_q    <= TMR_W'(CYC_STB - 1);
                  state_q  <= H_STB;
               end
            end
            H_STB: begin
               if (tmr_q == '0) begin
                  strobe_q <= 1'b0;
                  state_q  <= H_DONE;
               end else begin
                  tmr_q <= tmr_q - TMR_W'(1);
               end
            end
            H_DONE: begin
               done_q  <= 1'b1;
               state_q <= H_IDLE;
            end
            default: begin
               state_q <= H_IDLE;
            end
         endcase
      end
   end

   // blank while shifting into open latches
   always_ff @(posedge clk) begin
      if (!rstn) begin
         blank_q <= BLANK_RST;
      end else if (ce) begin
         blank_q <= blank_req |
                    (follow_q & (state_q != H_IDLE)) |
                    (follow_mode & word_valid & (state_q == H_IDLE));
      end
   end

   // cascade return synchroniser
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sout_s1_q <= 1'b0;
         sout_s2_q <= 1'b0;
      end else if (ce) begin
         sout_s1_q <= link.sout;
         sout_s2_q <= sout_s1_q;
      end
   end

   // previous contents collected just before each rise
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rb_q <= '0;
      end else if (ce && state_q == H_LOW && tmr_q == '0) begin
         rb_q <= {rb_q[SLD_BITS-2:0], sout_s2_q};
      end
   end

   assign word_ready  = ce & (state_q == H_IDLE);
   assign busy        = (state_q != H_IDLE);
   assign done        = done_q;
   assign readback    = rb_q;
   assign link.sclk   = sclk_q;
   assign link.sdata  = sdata_q;
   assign link.strobe = strobe_q;
   assign link.blank  = blank_q;

endmodule
`default_nettype wire

//--- dv/sld_link_props.sv
`timescale 1ns/10ps
`default_nettype none
module sld_link_props (
   input wire logic clk,
   input wire logic rstn,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic strobe,
   input wire logic blank,
   input wire logic sout
);
   logic       sclk_q;
   logic [7:0] gap_q;
   logic       rise;

   assign rise = sclk & ~sclk_q;

   always_ff @(posedge clk) begin
      sclk_q <= sclk;
   end

   // cycles since the last shift clock rise
   always_ff @(posedge clk) begin
      if (!rstn) begin
         gap_q <= 8'hFF;
      end else if (rise) begin
         gap_q <= 8'h00;
      end else if (gap_q != 8'hFF) begin
         gap_q <= gap_q + 8'h01;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_clk_high;
      $rose(sclk) |-> sclk [*6];
   endproperty
   a_clk_high: assert property (p_clk_high)
      else $error("shift clock pulse too short");

   property p_data_hold;
      $rose(sclk) |-> $stable(sdata) [*6];
   endproperty
   a_data_hold: assert property (p_data_hold)
      else $error("serial data not held after rise");

   property p_data_setup;
      $rose(sclk) |-> $past(sdata, 3) == sdata;
   endproperty
   a_data_setup: assert property (p_data_setup)
      else $error("serial data not set up before rise");

   property p_period;
      rise |-> gap_q >= 8'h0C;
   endproperty
   a_period: assert property (p_period)
      else $error("shift clock too fast");

   property p_stb_wait;
      $rose(strobe) |-> gap_q >= 8'h0B;
   endproperty
   a_stb_wait: assert property (p_stb_wait)
      else $error("transfer too soon after shift");

   property p_stb_width;
      $rose(strobe) |-> strobe [*4];
   endproperty
   a_stb_width: assert property (p_stb_width)
      else $error("transfer pulse too short");

   property p_blank_shift;
      $rose(sclk) && strobe |-> blank;
   endproperty
   a_blank_shift: assert property (p_blank_shift)
      else $error("shift with open latches unblanked");

   property p_sout_moves;
      $changed(sout) |-> rise;
   endproperty
   a_sout_moves: assert property (p_sout_moves)
      else $error("serial output moved without a rise");

   c_strobe: cover property ($rose(strobe));
   c_follow: cover property ($rose(sclk) && strobe);
   c_unblank: cover property ($fell(blank));
endmodule
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
   import sld_pkg::*;
   ;
   logic             clk;
   logic             rstn;
   logic             clr_err;
   sld_word_t        word_in;
   logic             word_valid;
   logic             word_ready;
   logic             follow_mode;
   logic             blank_req;
   logic             busy;
   logic             done;
   sld_word_t        readback;
   sld_word_t        src_on;
   sld_word_t        pd_on;
   sld_word_t        latch_word;
   sld_word_t        shadow_word;
   logic [CNT_W-1:0] frame_bits;
   logic             bits_passed;
   logic             blank_seen;
   logic             shift_seen;
   logic             err_early;
   logic             err_unblanked;
   int               fails;
   int               tests_run;

   sld_link_if link ();

   sld_host i_sld_host (.clk(clk), .rstn(rstn), .ce(1'b1), .link(link),
      .word_in(word_in), .word_valid(word_valid), .word_ready(word_ready),
      .follow_mode(follow_mode), .blank_req(blank_req), .busy(busy),
      .done(done), .readback(readback));

   sld_dev i_sld_dev (.clk(clk), .rstn(rstn), .ce(1'b1), .link(link),
      .clr_err(clr_err), .src_on(src_on), .pd_on(pd_on),
      .latch_word(latch_word), .shadow_word(shadow_word),
      .frame_bits(frame_bits), .bits_passed(bits_passed),
      .blank_seen(blank_seen), .shift_seen(shift_seen),
      .err_early(err_early), .err_unblanked(err_unblanked));

   sld_link_props i_sld_link_props (.clk(clk), .rstn(rstn),
      .sclk(link.sclk), .sdata(link.sdata), .strobe(link.strobe),
      .blank(link.blank), .sout(link.sout));

   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   task automatic chk(input string what, input sld_word_t seen,
                      input sld_word_t exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic ticks(input int n);
      repeat (n) @(negedge clk);
   endtask

   // one transfer; mid-frame look at latches or blanked outputs
   task automatic send(input sld_word_t w, input logic fol,
                       input sld_word_t mid);
      int n;
      int s;
      n = 0;
      s = 0;
      while (word_ready !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      if (word_ready !== 1'b1) begin
         fails++;
         $display("[FAIL] ready expected 1 seen 0");
         test_done();
      end
      word_in = w;
      follow_mode = fol;
      word_valid = 1'b1;
      @(negedge clk);
      word_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 600) begin
         @(negedge clk);
         n++;
         if (shift_seen === 1'b1) begin
            s++;
         end
         if (n == 150) begin
            chk("busy", busy, 20'h00001);
         end
         if (n == 150 && fol) begin
            chk("mid src", src_on, 20'h00000);
         end else if (n == 150) begin
            chk("mid latch", latch_word, mid);
         end
      end
      if (done !== 1'b1) begin
         fails++;
         $display("[FAIL] done expected 1 seen 0");
         test_done();
      end
      chk("shifts", sld_word_t'(s), sld_word_t'(SLD_BITS));
   endtask

   task automatic t_shift();
      send(20'hA5C3E, 1'b0, 20'h00000);
      ticks(6);
      chk("latch", latch_word, 20'hA5C3E);
      chk("shadow", shadow_word, 20'hA5C3E);
      chk("src", src_on, 20'hA5C3E);
      chk("pd", pd_on, 20'h5A3C1);
      chk("frame bits", frame_bits, 20'h00000);
      send(20'h5A3C1, 1'b0, 20'hA5C3E);
      chk("readback", readback, 20'hA5C3E);
      ticks(6);
      chk("latch", latch_word, 20'h5A3C1);
      $display("test shift finished");
   endtask

   task automatic t_blank();
      blank_req = 1'b1;
      ticks(8);
      chk("blank src", src_on, 20'h00000);
      chk("blank pd", pd_on, 20'hFFFFF);
      chk("blank latch", latch_word, 20'h5A3C1);
      chk("blank seen", blank_seen, 20'h00001);
      blank_req = 1'b0;
      ticks(8);
      chk("unblank src", src_on, 20'h5A3C1);
      chk("unblank seen", blank_seen, 20'h00000);
      $display("test blank finished");
   endtask

   task automatic t_follow();
      send(20'h0F00F, 1'b1, 20'h00000);
      chk("readback", readback, 20'h5A3C1);
      chk("follow latch", latch_word, 20'h0F00F);
      ticks(8);
      chk("follow src", src_on, 20'h0F00F);
      chk("early", err_early, 20'h00000);
      chk("unblanked", err_unblanked, 20'h00000);
      chk("frame bits", frame_bits, 20'h00014);
      chk("passed", bits_passed, 20'h00000);
      send(20'h3C5A6, 1'b1, 20'h00000);
      chk("cascade", readback, 20'h0F00F);
      chk("passed", bits_passed, 20'h00001);
      chk("follow latch", latch_word, 20'h3C5A6);
      chk("frame bits", frame_bits, 20'h00014);
      $display("test follow finished");
   endtask

   initial begin
      rstn = 1'b0;
      clr_err = 1'b0;
      word_in = 20'h00000;
      word_valid = 1'b0;
      follow_mode = 1'b0;
      blank_req = 1'b0;
      fails = 0;
      tests_run = 0;
      ticks(12);
      rstn = 1'b1;
      t_shift();
      t_blank();
      t_follow();
      test_done();
   end
endmodule
`default_nettype wire
